// >>> rtl/mss_defs.svh
// Constants of the motor starter slave: offsets, fields, resets, timing
`ifndef MSS_DEFS_SVH
`define MSS_DEFS_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define MSS_CLK_PERIOD_NS 8
`define MSS_WDG_TIMEOUT_US 1000
`define MSS_WDG_TIMEOUT_CYCLES ((`MSS_WDG_TIMEOUT_US * 1000) / `MSS_CLK_PERIOD_NS)

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define MSS_OFS_CMD 4'h0
`define MSS_OFS_STATUS 4'h4
`define MSS_OFS_CONFIG 4'h8
`define MSS_OFS_PROFILE 4'hc

// ----------------------------------------
// Command fields
// ----------------------------------------
`define MSS_CMD_FWD 0
`define MSS_CMD_REV 1
`define MSS_CMD_BRAKE 2
`define MSS_CMD_RRESET 3
`define MSS_CMD_RESET 4'h0

// ----------------------------------------
// Status fields
// ----------------------------------------
`define MSS_ST_READY 0
`define MSS_ST_RUNNING 1
`define MSS_ST_SPARE1 2
`define MSS_ST_SPARE2 3
`define MSS_ST_MANUAL 8
`define MSS_ST_TRIP 9
`define MSS_ST_FAULT 10
`define MSS_ST_DIRCONF 11
`define MSS_ST_HWFAULT 12
`define MSS_ST_WDGEXP 13
`define MSS_ST_RTRIP 14

// ----------------------------------------
// Config fields
// ----------------------------------------
`define MSS_CFG_ELEC 0
`define MSS_CFG_BRAKE 1
`define MSS_CFG_WDGEN 2
`define MSS_CFG_RESET 3'h4

// ----------------------------------------
// Profile codes
// ----------------------------------------
`define MSS_IO_CODE 4'h7
`define MSS_ID_CONTACTOR 4'hd
`define MSS_ID_ELECTRONIC 4'he

// ----------------------------------------
// Avalon responses
// ----------------------------------------
`define MSS_RESP_OK 2'h0
`define MSS_RESP_SLVERR 2'h2

`endif

// >>> rtl/mss_pkg.sv
// Types shared by the motor starter slave modules
package mss_pkg;

   typedef enum logic [1:0] {
      WDG_OFF,
      WDG_RUN,
      WDG_EXPIRED
   } mss_wdg_st_t;

   typedef enum logic {
      BUS_IDLE,
      BUS_ACK
   } mss_bus_st_t;

   typedef struct packed {
      mss_wdg_st_t st;
      logic [31:0] cnt;
   } mss_wdg_state_t;

   typedef struct packed {
      mss_bus_st_t bus;
      logic [31:0] rdata;
      logic [1:0] resp;
      logic [3:0] cmd;
      logic [2:0] cfg;
      logic hw_fault;
      logic etrip;
      logic rreset_prev;
      logic exp_prev;
      logic [3:0] pins;
      logic [3:0] din;
      logic [6:0] diag;
   } mss_state_t;

endpackage

// >>> rtl/mss_wdg_if.sv
// Carrier between the slave core and its communication watchdog
`timescale 1ns/10ps
interface mss_wdg_if;
   logic enable;
   logic kick;
   logic expired;

   modport ctrl (
      output enable,
      output kick,
      input expired
   );

   modport wdg (
      input enable,
      input kick,
      output expired
   );
endinterface

// >>> rtl/mss_watchdog.sv
// Communication watchdog: expires when the master stops writing commands
`timescale 1ns/10ps
module mss_watchdog
   import mss_pkg::*;
#(
   parameter int unsigned TIMEOUT_CYCLES = 125000
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic resetn_i,
   // Watchdog control
   mss_wdg_if.wdg wdg
);

   mss_wdg_state_t q;
   mss_wdg_state_t d;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      d = q;
      case (q.st)
         WDG_OFF: begin
            d.cnt = 32'h0;
            if (wdg.enable) begin
               d.st = WDG_RUN;
            end
         end
         WDG_RUN: begin
            if (!wdg.enable) begin
               d.st = WDG_OFF;
            end else if (wdg.kick) begin
               d.cnt = 32'h0;
            end else if (q.cnt == 32'(TIMEOUT_CYCLES - 1)) begin
               d.st = WDG_EXPIRED;
            end else begin
               d.cnt = q.cnt + 32'h1;
            end
         end
         WDG_EXPIRED: begin
            // Only a fresh command write from the master revives the link
            d.cnt = 32'h0;
            if (!wdg.enable) begin
               d.st = WDG_OFF;
            end else if (wdg.kick) begin
               d.st = WDG_RUN;
            end
         end
         default: begin
            d.st = WDG_OFF;
            d.cnt = 32'h0;
         end
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         q <= '{st: WDG_OFF, cnt: 32'h0};
      end else begin
         q <= d;
      end
   end

   assign wdg.expired = (q.st == WDG_EXPIRED);

endmodule

// >>> rtl/mss_slave.sv
// Process-data core of a bus-connected motor starter slave
//
// Our own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/10ps
`include "mss_defs.svh"

// Functional notes
// - Ready bit is 1 when ready and automatic
// - Ready bit 0 on any error or trip except watchdog expiry
// - Manual mode clears ready, ignores bus run commands
// - Contactor variant: breaker trip clears ready
// - Coil, welded contact, driver faults clear ready
// - Both directions commanded is a fault
// - Electronic local trip: load off, not ready
// - Electronic remote trip: flag, master decides
// - Electronic fault detections clear ready bit
// - Hardware fault holds until fixed and reset
// - Map bits per profile 7D or 7E
// - Brake output only where brake fitted
// - Brake follows its bit, independent of motor
// - Remote reset clears electronic overload trip
// - Watchdog switches outputs off on bus loss
module mss_slave
   import mss_pkg::*;
#(
   parameter int unsigned WDG_TIMEOUT_CYCLES = `MSS_WDG_TIMEOUT_CYCLES
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic resetn_i,
   // Avalon-MM slave
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic [1:0] avs_response_o,
   output logic avs_waitrequest_o,
   // Local mode and common sensors
   input wire logic manual_mode_i,
   input wire logic contactor_on_i,
   input wire logic load_current_i,
   input wire logic spare_sensor_one_i,
   input wire logic spare_sensor_two_i,
   // Contactor variant detections
   input wire logic breaker_tripped_i,
   input wire logic coil_defect_i,
   input wire logic contact_welded_i,
   input wire logic driver_defect_i,
   // Electronic variant detections
   input wire logic overload_trip_i,
   input wire logic trip_remote_sel_i,
   input wire logic no_current_i,
   input wire logic two_phase_loss_i,
   input wire logic connector_drawn_i,
   input wire logic supply_low_i,
   input wire logic imbalance_i,
   input wire logic main_circuit_fault_i,
   input wire logic hw_fault_i,
   // Actuator outputs
   output logic forward_run_cmd_o,
   output logic reverse_run_cmd_o,
   output logic brake_cmd_o,
   output logic remote_reset_cmd_o,
   // Process input image
   output logic ready_status_bit_o,
   output logic running_status_bit_o,
   output logic spare_info_one_bit_o,
   output logic spare_info_two_bit_o
);

   mss_state_t q;
   mss_state_t d;
   mss_wdg_if wdg_if ();

   logic elec;
   logic rr_edge;
   logic dir_conflict;
   logic fault_mech;
   logic fault_elec;
   logic local_shutoff;
   logic motor_en;
   logic wdg_exp;
   logic ready;
   logic running;
   logic [2:0] rd_sel;
   logic [2:0] wr_sel;
   logic [31:0] status_word;
   logic [31:0] profile_word;
   logic [31:0] rd_word;
   logic wr_take;

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   // Returns {valid, index}; misaligned addresses are unmapped
   function automatic logic [2:0] reg_sel(input logic [3:0] addr);
      logic [2:0] sel;
      sel = 3'h0;
      case (addr)
         `MSS_OFS_CMD: sel = 3'h4;
         `MSS_OFS_STATUS: sel = 3'h5;
         `MSS_OFS_CONFIG: sel = 3'h6;
         `MSS_OFS_PROFILE: sel = 3'h7;
         default: sel = 3'h0;
      endcase
      return sel;
   endfunction

   assign rd_sel = reg_sel(avs_address_i);
   assign wr_sel = reg_sel(avs_address_i);

   // ----------------------------------------
   // Watchdog
   // ----------------------------------------
   mss_watchdog #(
      .TIMEOUT_CYCLES(WDG_TIMEOUT_CYCLES)
   ) u_wdg (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .wdg(wdg_if.wdg)
   );

   assign wr_take = (q.bus == BUS_ACK) && avs_write_i;
   assign wdg_if.enable = q.cfg[`MSS_CFG_WDGEN];
   // Only CMD writes kick: status polling alone does not prove the programme runs
   assign wdg_if.kick = wr_take && (wr_sel == 3'h4);
   assign wdg_exp = wdg_if.expired;

   // ----------------------------------------
   // Fault evaluation
   // ----------------------------------------
   assign elec = q.cfg[`MSS_CFG_ELEC];
   assign rr_edge = q.cmd[`MSS_CMD_RRESET] && !q.rreset_prev;
   assign dir_conflict = q.cmd[`MSS_CMD_FWD] && q.cmd[`MSS_CMD_REV];
   assign fault_mech = !elec && (breaker_tripped_i ||
                                 coil_defect_i ||
                                 contact_welded_i ||
                                 driver_defect_i);
   assign fault_elec = elec && (q.etrip ||
                                no_current_i ||
                                two_phase_loss_i ||
                                connector_drawn_i ||
                                supply_low_i ||
                                imbalance_i ||
                                main_circuit_fault_i ||
                                q.hw_fault);
   assign local_shutoff = elec && q.etrip && !trip_remote_sel_i;
   assign ready = !manual_mode_i &&
                  !fault_mech &&
                  !fault_elec &&
                  !dir_conflict;
   assign running = elec ? load_current_i : contactor_on_i;
   // Manual mode hands the motor to the local unit, so bus run commands are masked
   assign motor_en = !dir_conflict &&
                     !wdg_exp &&
                     !local_shutoff &&
                     !manual_mode_i;

   // ----------------------------------------
   // Register images
   // ----------------------------------------
   always_comb begin
      status_word = 32'h0;
      status_word[3:0] = q.din;
      status_word[`MSS_ST_MANUAL] = q.diag[0];
      status_word[`MSS_ST_TRIP] = q.diag[1];
      status_word[`MSS_ST_FAULT] = q.diag[2];
      status_word[`MSS_ST_DIRCONF] = q.diag[3];
      status_word[`MSS_ST_HWFAULT] = q.diag[4];
      status_word[`MSS_ST_WDGEXP] = q.diag[5];
      status_word[`MSS_ST_RTRIP] = q.diag[6];
   end

   always_comb begin
      profile_word = 32'h0;
      profile_word[3:0] = `MSS_IO_CODE;
      if (elec) begin
         profile_word[7:4] = `MSS_ID_ELECTRONIC;
      end else begin
         profile_word[7:4] = `MSS_ID_CONTACTOR;
      end
   end

   always_comb begin
      case (rd_sel)
         3'h4: rd_word = {28'h0, q.cmd};
         3'h5: rd_word = status_word;
         3'h6: rd_word = {29'h0, q.cfg};
         3'h7: rd_word = profile_word;
         default: rd_word = 32'h0;
      endcase
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      d = q;
      d.rreset_prev = q.cmd[`MSS_CMD_RRESET];
      d.exp_prev = wdg_exp;

      // Set wins over clear so a cause still present is never lost
      // hold until fixed and reset
      if (elec && hw_fault_i) begin
         d.hw_fault = 1'b1;
      end else if (rr_edge || !elec) begin
         d.hw_fault = 1'b0;
      end

      if (elec && overload_trip_i) begin
         d.etrip = 1'b1;
      end else if (rr_edge || !elec) begin
         d.etrip = 1'b0;
      end

      if (wdg_exp && !q.exp_prev) begin
         d.cmd = `MSS_CMD_RESET;
      end

      // Bus slave: take in idle, answer one cycle later
      case (q.bus)
         BUS_IDLE: begin
            if (avs_read_i || avs_write_i) begin
               d.bus = BUS_ACK;
               d.resp = rd_sel[2] ? `MSS_RESP_OK : `MSS_RESP_SLVERR;
               // Writes answer with zero data so no stale word is returned
               d.rdata = avs_read_i ? rd_word : 32'h0;
            end
         end
         BUS_ACK: begin
            d.bus = BUS_IDLE;
            // Write lands at the edge that ends the acknowledge cycle, one edge after the wait state ends
            if (wr_take && avs_byteenable_i[0]) begin
               if (wr_sel == 3'h4) begin
                  d.cmd = avs_writedata_i[3:0];
               end else if (wr_sel == 3'h6) begin
                  d.cfg = avs_writedata_i[2:0];
               end
            end
         end
         default: begin
            d.bus = BUS_IDLE;
         end
      endcase

      d.pins[`MSS_CMD_FWD] = q.cmd[`MSS_CMD_FWD] && motor_en;
      d.pins[`MSS_CMD_REV] = q.cmd[`MSS_CMD_REV] && motor_en;
      // Brake skips motor_en so a local trip cannot drop a held load
      // only with brake fitted
      d.pins[`MSS_CMD_BRAKE] = q.cmd[`MSS_CMD_BRAKE] &&
                               q.cfg[`MSS_CFG_BRAKE] &&
                               !wdg_exp;
      d.pins[`MSS_CMD_RRESET] = q.cmd[`MSS_CMD_RRESET] &&
                                elec &&
                                !wdg_exp;

      d.din[`MSS_ST_READY] = ready;
      d.din[`MSS_ST_RUNNING] = running;
      d.din[`MSS_ST_SPARE1] = spare_sensor_one_i;
      d.din[`MSS_ST_SPARE2] = spare_sensor_two_i;

      d.diag[0] = manual_mode_i;
      d.diag[1] = elec ? q.etrip : breaker_tripped_i;
      d.diag[2] = fault_mech || fault_elec;
      d.diag[3] = dir_conflict;
      d.diag[4] = q.hw_fault;
      d.diag[5] = wdg_exp;
      d.diag[6] = q.etrip && trip_remote_sel_i;
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         q <= '{bus: BUS_IDLE,
                rdata: 32'h0,
                resp: `MSS_RESP_OK,
                cmd: `MSS_CMD_RESET,
                cfg: `MSS_CFG_RESET,
                hw_fault: 1'b0,
                etrip: 1'b0,
                rreset_prev: 1'b0,
                exp_prev: 1'b0,
                pins: 4'h0,
                din: 4'h0,
                diag: 7'h0};
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign avs_waitrequest_o = (avs_read_i || avs_write_i) && (q.bus != BUS_ACK);
   assign avs_readdata_o = q.rdata;
   assign avs_response_o = q.resp;

   logic [3:0] pin_vec;
   logic [3:0] din_vec;

   generate
      for (genvar i = 0; i < 4; i++) begin : g_bits
         assign pin_vec[i] = q.pins[i];
         assign din_vec[i] = q.din[i];
      end
   endgenerate

   assign forward_run_cmd_o = pin_vec[`MSS_CMD_FWD];
   assign reverse_run_cmd_o = pin_vec[`MSS_CMD_REV];
   assign brake_cmd_o = pin_vec[`MSS_CMD_BRAKE];
   assign remote_reset_cmd_o = pin_vec[`MSS_CMD_RRESET];
   assign ready_status_bit_o = din_vec[`MSS_ST_READY];
   assign running_status_bit_o = din_vec[`MSS_ST_RUNNING];
   assign spare_info_one_bit_o = din_vec[`MSS_ST_SPARE1];
   assign spare_info_two_bit_o = din_vec[`MSS_ST_SPARE2];

endmodule

// >>> dv/mss_slave_asserts.sv
// Checker of the motor starter slave port behaviour
`timescale 1ns/10ps
module mss_slave_asserts (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic resetn_i,
   // Bus and local inputs
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic avs_waitrequest_o,
   input wire logic [1:0] avs_response_o,
   input wire logic manual_mode_i,
   input wire logic contactor_on_i,
   input wire logic load_current_i,
   input wire logic spare_sensor_one_i,
   input wire logic spare_sensor_two_i,
   // Observed outputs
   input wire logic forward_run_cmd_o,
   input wire logic reverse_run_cmd_o,
   input wire logic ready_status_bit_o,
   input wire logic running_status_bit_o,
   input wire logic spare_info_one_bit_o,
   input wire logic spare_info_two_bit_o
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!resetn_i);
   // ----------------------------------------
   // Bus cycle steps
   // ----------------------------------------
   sequence s_req_wait;
      (avs_read_i || avs_write_i) && avs_waitrequest_o;
   endsequence
   sequence s_ack;
      (avs_read_i || avs_write_i) && !avs_waitrequest_o;
   endsequence
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   a_bus_one_wait: assert property (s_req_wait |=> s_ack)
      else $error("bus answer not after one wait");
   a_unmapped_err: assert property (s_ack ##0 (avs_address_i[1:0] != 2'h0)
      |-> avs_response_o == 2'h2) else $error("unmapped access not refused");
   a_mapped_ok: assert property (s_ack ##0 (avs_address_i[1:0] == 2'h0)
      |-> avs_response_o == 2'h0) else $error("mapped access refused");
   a_manual_ready: assert property (
      manual_mode_i |=> !ready_status_bit_o) else $error("ready set in manual mode");
   a_manual_motor: assert property (
      manual_mode_i |=> !forward_run_cmd_o && !reverse_run_cmd_o)
      else $error("motor driven in manual mode");
   a_no_dir_conflict: assert property (
      !(forward_run_cmd_o && reverse_run_cmd_o)) else $error("both directions driven");
   a_spare_one_mirror: assert property (
      $past(resetn_i) |-> spare_info_one_bit_o == $past(spare_sensor_one_i))
      else $error("spare one not mirrored");
   a_spare_two_mirror: assert property (
      $past(resetn_i) |-> spare_info_two_bit_o == $past(spare_sensor_two_i))
      else $error("spare two not mirrored");
   a_running_off: assert property (
      !contactor_on_i && !load_current_i |=> !running_status_bit_o)
      else $error("running without contactor or current");
endmodule

bind mss_slave mss_slave_asserts u_chk (.*);

// >>> dv/mss_avm_model.sv
// Bus master model standing in for the fieldbus controller
`timescale 1ns/10ps
module mss_avm_model (
   // Clock
   input wire logic core_clk_i,
   // Slave answers
   input wire logic avs_waitrequest_o,
   input wire logic [31:0] avs_readdata_o,
   input wire logic [1:0] avs_response_o,
   // Master requests
   output logic [3:0] avs_address_i,
   output logic avs_read_i,
   output logic avs_write_i,
   output logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_writedata_i
);
   initial begin
      avs_address_i = 4'h0;
      avs_read_i = 1'b0;
      avs_write_i = 1'b0;
      avs_byteenable_i = 4'hf;
      avs_writedata_i = 32'h0;
   end
   // Request is held until waitrequest is seen low; no fixed latency assumed
   task automatic xfer(input logic w, input logic [3:0] a, input logic [3:0] be,
         input logic [31:0] d, output logic [31:0] q, output logic [1:0] r);
      @(posedge core_clk_i);
      avs_address_i <= a;
      avs_byteenable_i <= be;
      avs_writedata_i <= d;
      avs_write_i <= w;
      avs_read_i <= !w;
      do @(posedge core_clk_i); while (avs_waitrequest_o !== 1'b0);
      q = avs_readdata_o;
      r = avs_response_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
   endtask
endmodule

// >>> dv/mss_slave_test.sv
// Self-checking bench of the motor starter slave
`timescale 1ns/10ps
module mss_slave_test;
   logic core_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic [17:0] fi = 18'h0;
   wire logic [3:0] avs_address_i, avs_byteenable_i;
   wire logic avs_read_i, avs_write_i, avs_waitrequest_o;
   wire logic [31:0] avs_writedata_i, avs_readdata_o;
   wire logic [1:0] avs_response_o;
   wire logic manual_mode_i, contactor_on_i, load_current_i, spare_sensor_one_i;
   wire logic spare_sensor_two_i, breaker_tripped_i, coil_defect_i, contact_welded_i;
   wire logic driver_defect_i, overload_trip_i, trip_remote_sel_i, no_current_i;
   wire logic two_phase_loss_i, connector_drawn_i, supply_low_i, imbalance_i;
   wire logic main_circuit_fault_i, hw_fault_i;
   wire logic forward_run_cmd_o, reverse_run_cmd_o, brake_cmd_o, remote_reset_cmd_o;
   wire logic ready_status_bit_o, running_status_bit_o;
   wire logic spare_info_one_bit_o, spare_info_two_bit_o;
   int fails = 0;
   int n_checks = 0;
   int cyc = 0;
   int i;
   logic [3:0] cmd = 4'h0;
   logic [2:0] cfg = 3'h4;
   logic trip = 1'b0;
   logic hwf = 1'b0;
   logic exp_w = 1'b0;
   logic [15:0] lf = 16'h9a15;

   assign {manual_mode_i, contactor_on_i, load_current_i, spare_sensor_one_i,
      spare_sensor_two_i, breaker_tripped_i, coil_defect_i, contact_welded_i,
      driver_defect_i, overload_trip_i, trip_remote_sel_i, no_current_i,
      two_phase_loss_i, connector_drawn_i, supply_low_i, imbalance_i,
      main_circuit_fault_i, hw_fault_i} = fi;

   // Short watchdog so bus loss is reached quickly
   mss_slave #(.WDG_TIMEOUT_CYCLES(400)) dut (.*);
   mss_avm_model m (.*);

   always #4 core_clk_i = ~core_clk_i;

   function automatic logic [15:0] lfsr(logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // Expected pins and image: {fwd, rev, brake, rreset, ready, running, sp1, sp2}
   function automatic logic [7:0] exp_out();
      logic el, cf, lt, rd;
      el = cfg[0];
      cf = cmd[0] & cmd[1];
      lt = el & trip & !fi[7];
      rd = !fi[17] & !cf & (el ? !(trip | hwf | (|fi[6:1])) : !(|fi[12:9]));
      return {cmd[0] & !cf & !exp_w & !lt & !fi[17], cmd[1] & !cf & !exp_w & !lt & !fi[17],
         cmd[2] & cfg[1] & !exp_w, cmd[3] & el & !exp_w, rd, el ? fi[15] : fi[16],
         fi[14], fi[13]};
   endfunction

   task automatic complete_run();
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(string nm, logic [31:0] got, logic [31:0] ex);
      n_checks++;
      if (got !== ex) begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, ex, got);
      end
   endtask

   // Latches lag their cause by one cycle, pins by one more
   task automatic pins();
      repeat (4) @(posedge core_clk_i);
      chk("pins", {24'h0, forward_run_cmd_o, reverse_run_cmd_o, brake_cmd_o,
         remote_reset_cmd_o, ready_status_bit_o, running_status_bit_o,
         spare_info_one_bit_o, spare_info_two_bit_o}, {24'h0, exp_out()});
   endtask

   task automatic setin(logic [17:0] v);
      @(posedge core_clk_i);
      fi <= v;
      trip = trip | (cfg[0] & v[8]);
      hwf = hwf | (cfg[0] & v[0]);
   endtask

   task automatic wr(logic [3:0] a, logic [31:0] d, logic [3:0] be = 4'hf);
      logic [31:0] q;
      logic [1:0] r;
      m.xfer(1'b1, a, be, d, q, r);
      // Model follows the write once it lands, against the inputs of that cycle
      if (a == 4'h0) begin
         exp_w = 1'b0;
      end
      if (a == 4'h0 && be[0]) begin
         trip = trip & !(!cmd[3] & d[3] & !fi[8]);
         hwf = hwf & !(!cmd[3] & d[3] & !fi[0]);
         cmd = d[3:0];
      end
      if (a == 4'h8 && be[0]) begin
         cfg = d[2:0];
         trip = trip & cfg[0];
         hwf = hwf & cfg[0];
      end
      chk("wresp", {30'h0, r}, (a[1:0] != 2'h0) ? 32'h2 : 32'h0);
   endtask

   task automatic rd(logic [3:0] a, logic [31:0] ex, logic [31:0] mk);
      logic [31:0] q;
      logic [1:0] r;
      m.xfer(1'b0, a, 4'hf, 32'h0, q, r);
      chk("rdata", q & mk, ex);
      chk("rresp", {30'h0, r}, (a[1:0] != 2'h0) ? 32'h2 : 32'h0);
   endtask

   // ----------------------------------------
   // Hang guard
   // ----------------------------------------
   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc == 6000) begin
         fails++;
         complete_run();
      end
   end

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      repeat (8) @(posedge core_clk_i);
      resetn_i <= 1'b1;
      rd(4'h8, 32'h4, 32'hffffffff);
      rd(4'h0, 32'h0, 32'hffffffff);
      rd(4'hc, 32'hd7, 32'hffffffff);
      rd(4'h2, 32'h0, 32'hffffffff);
      wr(4'hc, 32'h0);
      rd(4'hc, 32'hd7, 32'hffffffff);
      wr(4'h8, 32'h6);
      wr(4'h0, 32'h5);
      pins();
      wr(4'h0, 32'h6);
      pins();
      wr(4'h0, 32'h3);
      pins();
      wr(4'h8, 32'h4);
      wr(4'h0, 32'h5);
      pins();
      for (i = 0; i < 4; i++) begin
         setin(18'h200 << i);
         pins();
      end
      setin(18'h20000);
      wr(4'h0, 32'h1);
      pins();
      setin(18'h0);
      pins();
      wr(4'h8, 32'h5);
      rd(4'hc, 32'he7, 32'hffffffff);
      for (i = 1; i < 7; i++) begin
         setin(18'h1 << i);
         pins();
      end
      setin(18'h100);
      pins();
      setin(18'h0);
      pins();
      wr(4'h0, 32'h9);
      pins();
      wr(4'h0, 32'h1);
      setin(18'h180);
      pins();
      // Master drops the motor after a flagged trip
      wr(4'h0, 32'h0);
      pins();
      setin(18'h0);
      wr(4'h0, 32'h8);
      pins();
      setin(18'h1);
      pins();
      setin(18'h0);
      pins();
      wr(4'h0, 32'h1);
      wr(4'h0, 32'h9);
      pins();
      // A write without its low byte lane leaves the command as it was
      wr(4'h0, 32'h2, 4'he);
      pins();
      for (i = 0; i < 20; i++) begin
         if (i == 10) begin
            wr(4'h8, 32'h4);
         end
         lf = lfsr(lf);
         setin({1'b0, lf[3:0], 13'h0});
         pins();
      end
      wr(4'h8, 32'h6);
      wr(4'h0, 32'h5);
      repeat (410) @(posedge core_clk_i);
      cmd = 4'h0;
      exp_w = 1'b1;
      chk("wdg", {28'h0, forward_run_cmd_o, reverse_run_cmd_o, brake_cmd_o,
         remote_reset_cmd_o}, 32'h0);
      rd(4'h4, 32'h2000, 32'h2000);
      wr(4'h0, 32'h1);
      pins();
      complete_run();
   end
endmodule
